// [core/vic_map.vh]
// vic_map.vh: constants for the vectored interrupt controller
// assumes inclusion by core/vic_ctrl.v only
`ifndef VIC_MAP_VH
`define VIC_MAP_VH
`define VIC_NUM_IRQ 32
`define VIC_PRIO_W 2
`define VIC_IDX_W 5
`define VIC_WAKE_LO 0
`define VIC_WAKE_HI 10
`define VIC_IRQ_NFC_WAKE 11
`define VIC_IRQ_RTC_WAKE 12
`define VIC_IRQ_NFC 13
`define VIC_IRQ_RTC 14
`define VIC_IRQ_I2C 15
`define VIC_IRQ_T16 16
`define VIC_IRQ_PWR 17
`define VIC_IRQ_T32 18
`define VIC_IRQ_BROWN 19
`define VIC_IRQ_SPI 20
`define VIC_IRQ_TEMP 21
`define VIC_IRQ_CAP 22
`define VIC_IRQ_RSV0 23
`define VIC_IRQ_CUR 24
`define VIC_IRQ_ADC 25
`define VIC_IRQ_WDT 26
`define VIC_IRQ_FLASH 27
`define VIC_IRQ_EE 28
`define VIC_IRQ_RSV1 29
`define VIC_IRQ_RSV2 30
`define VIC_IRQ_GPIO 31
`define VIC_PRIO_NONE 3'h4
`define VIC_ST_IDLE 2'h0
`define VIC_ST_STACK 2'h1
`define VIC_ST_RUN 2'h2
`define VIC_ST_UNSTACK 2'h3
`define VIC_STACK_CYC 4'h8
`define VIC_NEST_MAX 3'h7
`define VIC_STACK_DEPTH 8
`endif

// [core/vic_ctrl.v]
// vic_ctrl.v: vectored interrupt controller with source aggregation and entry/exit sequencing
// assumes sources and the core run on clk; pin wake inputs are asynchronous and synchronised here
//
// Summary of operation
// (RULE_01) thirty-two request lines each have an interrupt number from zero and are vectored by that number.
// (RULE_02) each line has a two-bit programmed priority, and only priorities above the running level are taken.
// (RULE_03) among pending lines of equal priority the lowest interrupt number is served first.
// (RULE_04) entry saves and exit restores core state in hardware, with no instruction involvement.
// (RULE_05) a line is asserted while any of its enabled source flags is active.
// (RULE_06) lines 0 to 10 come from port zero pins 0 to 10 acting as deep-sleep wake sources.
// (RULE_07) line 11 is the wireless external-access wake and line 12 the clock-timer wake.
// (RULE_08) line 13 is the wireless access, command or read-acknowledge event.
// (RULE_09) line 14 is the real-time clock timer event.
// (RULE_10) lines 15 to 18 are the i2c state change, 16-bit timer matches, field power and 32-bit timer matches.
// (RULE_11) line 19 is the brownout detector.
// (RULE_12) line 20 combines the four spi fifo and receive conditions.
// (RULE_13) line 21 combines the three temperature sensor conditions.
// (RULE_14) lines 22 and 24 combine the three conditions of the capacitance and current converters.
// (RULE_15) line 31 is the combined port zero gpio status.
// (RULE_16) reserved lines 23, 29 and 30 are tied inactive.
`timescale 1ns/1ps
`include "vic_map.vh"

module vic_ctrl #(
    parameter NUM_IRQ = `VIC_NUM_IRQ,
    parameter STACK_CYC = `VIC_STACK_CYC
) (
    input wire clk, // core clock, 50 MHz
    input wire rst, // synchronous reset, active high
    input wire [10:0] wake_pin, // port zero pins 0..10, asynchronous
    input wire nfc_ext_access, // wireless external access wake
    input wire rtc_wake, // clock timer wake
    input wire [2:0] nfc_flags, // access, command, read ack
    input wire rtc_event, // rtc timer event
    input wire i2c_state_change, // i2c state change
    input wire [2:0] t16_match, // 16-bit timer matches 0..2
    input wire pwr_field_det, // power manager field detect
    input wire [1:0] t32_match, // 32-bit timer matches 0..1
    input wire brownout, // supply drop
    input wire [3:0] spi_flags, // tx half empty, rx half full, rx timeout, rx overrun
    input wire [3:0] spi_flag_en, // per-flag enables
    input wire [2:0] temp_flags, // end of conv, low, high
    input wire [2:0] temp_flag_en, // per-flag enables
    input wire [2:0] cap_flags, // end of conv, low, high
    input wire [2:0] cap_flag_en, // per-flag enables
    input wire [2:0] cur_flags, // end of conv, low, high
    input wire [2:0] cur_flag_en, // per-flag enables
    input wire adc_irq, // adc/dac interrupt
    input wire wdt_irq, // watchdog_irq_flag
    input wire flash_irq, // flash memory
    input wire ee_irq, // eeprom memory
    input wire gpio_status, // general_port_zero combined status
    input wire [NUM_IRQ-1:0] irq_enable, // per-line enable
    input wire [NUM_IRQ-1:0] sw_pend_set, // software pend pulses
    input wire [NUM_IRQ-1:0] sw_pend_clr, // software clear-pend pulses
    input wire [NUM_IRQ*2-1:0] irq_prio, // 2-bit priority per line
    input wire exc_return, // handler finished, pulse
    output wire [NUM_IRQ-1:0] irq_line, // aggregated request lines
    output reg [NUM_IRQ-1:0] pending_ff, // pending state
    output reg [NUM_IRQ-1:0] active_ff, // active state
    output reg [4:0] vector_ff, // vector of running handler
    output reg [2:0] run_level_ff, // running priority, 4 = thread
    output reg stacking_ff, // state save in progress
    output reg unstacking_ff, // state restore in progress
    output reg handler_start_ff // one-cycle pulse: handler begins
);
    reg [10:0] wsync1_ff;
    reg [10:0] wsync2_ff;
    reg [10:0] wsync3_ff;
    reg [10:0] wake_ff;
    reg [1:0] state_ff;
    reg [3:0] cnt_ff;
    localparam [1:0] ST_IDLE = `VIC_ST_IDLE;
    localparam [1:0] ST_STACK = `VIC_ST_STACK;
    localparam [1:0] ST_RUN = `VIC_ST_RUN;
    localparam [1:0] ST_UNSTACK = `VIC_ST_UNSTACK;

    reg [4:0] stack_vec_ff [0:`VIC_STACK_DEPTH-1];
    reg [2:0] stack_lvl_ff [0:`VIC_STACK_DEPTH-1];
    reg [2:0] depth_ff;
    reg [NUM_IRQ-1:0] lines;
    reg [4:0] best_idx;
    reg [2:0] best_pri;
    reg best_vld;
    integer i;
    integer j;

    function [1:0] prio_of;
        input [NUM_IRQ*2-1:0] p;
        input integer n;
        begin
            prio_of = p[n*2 +: 2];
        end
    endfunction

    // second and third stage agree before a pin change counts
    always @(posedge clk) begin
        if (rst) begin
            wsync1_ff <= 11'h000;
            wsync2_ff <= 11'h000;
            wsync3_ff <= 11'h000;
            wake_ff <= 11'h000;
        end else begin
            wsync1_ff <= wake_pin;
            wsync2_ff <= wsync1_ff;
            wsync3_ff <= wsync2_ff;
            wake_ff <= (wsync2_ff & wsync3_ff) | (wake_ff & (wsync2_ff | wsync3_ff));
        end
    end

    always @* begin
        lines = {NUM_IRQ{1'b0}};
        lines[`VIC_WAKE_HI:`VIC_WAKE_LO] = wake_ff; // [RULE_06]
        lines[`VIC_IRQ_NFC_WAKE] = nfc_ext_access; // [RULE_07]
        lines[`VIC_IRQ_RTC_WAKE] = rtc_wake; // [RULE_07]
        lines[`VIC_IRQ_NFC] = |nfc_flags; // [RULE_08] [RULE_05]
        lines[`VIC_IRQ_RTC] = rtc_event; // [RULE_09]
        lines[`VIC_IRQ_I2C] = i2c_state_change; // [RULE_10]
        lines[`VIC_IRQ_T16] = |t16_match; // [RULE_10]
        lines[`VIC_IRQ_PWR] = pwr_field_det; // [RULE_10]
        lines[`VIC_IRQ_T32] = |t32_match; // [RULE_10]
        lines[`VIC_IRQ_BROWN] = brownout; // [RULE_11]
        lines[`VIC_IRQ_SPI] = |(spi_flags & spi_flag_en); // [RULE_12] [RULE_05]
        lines[`VIC_IRQ_TEMP] = |(temp_flags & temp_flag_en); // [RULE_13]
        lines[`VIC_IRQ_CAP] = |(cap_flags & cap_flag_en); // [RULE_14]
        lines[`VIC_IRQ_CUR] = |(cur_flags & cur_flag_en); // [RULE_14]
        lines[`VIC_IRQ_RSV0] = 1'b0; // [RULE_16]
        lines[`VIC_IRQ_RSV1] = 1'b0; // [RULE_16]
        lines[`VIC_IRQ_RSV2] = 1'b0; // [RULE_16]
        lines[`VIC_IRQ_ADC] = adc_irq;
        lines[`VIC_IRQ_WDT] = wdt_irq;
        lines[`VIC_IRQ_FLASH] = flash_irq;
        lines[`VIC_IRQ_EE] = ee_irq;
        lines[`VIC_IRQ_GPIO] = gpio_status; // [RULE_15]
    end
    assign irq_line = lines;

    // descending scan with <= lets the lowest number win ties
    always @* begin
        best_idx = 5'h00;
        best_pri = `VIC_PRIO_NONE;
        best_vld = 1'b0;
        for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
            if (pending_ff[i] && irq_enable[i] && !active_ff[i]
                    && {1'b0, prio_of(irq_prio, i)} <= best_pri
                    && {1'b0, prio_of(irq_prio, i)} < run_level_ff) begin // [RULE_02] [RULE_03]
                best_idx = i[4:0]; // [RULE_01]
                best_pri = {1'b0, prio_of(irq_prio, i)};
                best_vld = 1'b1;
            end
        end
    end

    // an active line level sets pending every cycle; set wins over a simultaneous clear
    always @(posedge clk) begin
        if (rst) begin
            pending_ff <= {NUM_IRQ{1'b0}};
        end else begin
            // the line term keeps a still-active level source pending after entry
            pending_ff <= (pending_ff & ~sw_pend_clr & ~((state_ff == ST_STACK && cnt_ff == 4'h0)
                ? ({{(NUM_IRQ-1){1'b0}}, 1'b1} << vector_ff) : {NUM_IRQ{1'b0}}))
                | sw_pend_set | lines; // [RULE_05]
        end
    end

    // entry: save level and vector in hardware, then start the handler
    always @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            depth_ff <= 3'h0;
            active_ff <= {NUM_IRQ{1'b0}};
            vector_ff <= 5'h00;
            run_level_ff <= `VIC_PRIO_NONE;
            stacking_ff <= 1'b0;
            unstacking_ff <= 1'b0;
            handler_start_ff <= 1'b0;
            for (j = 0; j < `VIC_STACK_DEPTH; j = j + 1) begin
                stack_vec_ff[j] <= 5'h00;
                stack_lvl_ff[j] <= 3'h0;
            end
        end else begin
            handler_start_ff <= 1'b0;
            case (state_ff)
                ST_IDLE, ST_RUN: begin
                    // limitation: a return request in the cycle a preemption is taken is dropped
                    if (best_vld && depth_ff != `VIC_NEST_MAX) begin // [RULE_04]
                        stack_vec_ff[depth_ff] <= vector_ff;
                        stack_lvl_ff[depth_ff] <= run_level_ff;
                        depth_ff <= depth_ff + 3'h1;
                        vector_ff <= best_idx;
                        run_level_ff <= best_pri;
                        active_ff[best_idx] <= 1'b1;
                        cnt_ff <= STACK_CYC[3:0] - 4'h1;
                        stacking_ff <= 1'b1;
                        state_ff <= ST_STACK;
                    end else if (exc_return && state_ff == ST_RUN) begin
                        cnt_ff <= STACK_CYC[3:0] - 4'h1;
                        unstacking_ff <= 1'b1;
                        state_ff <= ST_UNSTACK;
                    end
                end
                ST_STACK: begin
                    if (cnt_ff == 4'h0) begin
                        stacking_ff <= 1'b0;
                        handler_start_ff <= 1'b1;
                        state_ff <= ST_RUN;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                ST_UNSTACK: begin
                    if (cnt_ff == 4'h0) begin // [RULE_04]
                        unstacking_ff <= 1'b0;
                        active_ff[vector_ff] <= 1'b0;
                        depth_ff <= depth_ff - 3'h1;
                        vector_ff <= stack_vec_ff[depth_ff - 3'h1];
                        run_level_ff <= stack_lvl_ff[depth_ff - 3'h1];
                        state_ff <= (depth_ff == 3'h1) ? ST_IDLE : ST_RUN;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // vic_ctrl

// [tb/vic_ctrl_props.sv]
// vic_ctrl_props.sv: concurrent checks on the interrupt controller ports
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
module vic_ctrl_props #(
    parameter NUM_IRQ = 32
) (
    input wire clk, // core clock
    input wire rst, // sync reset
    input wire [NUM_IRQ-1:0] irq_line, // aggregated lines
    input wire [NUM_IRQ-1:0] pending_ff, // pending state
    input wire [4:0] vector_ff, // running vector
    input wire [2:0] run_level_ff, // running level
    input wire stacking_ff, // state save
    input wire unstacking_ff, // state restore
    input wire handler_start_ff, // handler begins
    input wire [3:0] spi_flags, // spi conditions
    input wire [3:0] spi_flag_en, // spi enables
    input wire [2:0] t16_match, // timer matches
    input wire brownout // supply drop
);
    reg [NUM_IRQ-1:0] pend_q_ff;
    // one-cycle-old pending, so the taken line can be looked up by the new vector
    always @(posedge clk) begin
        pend_q_ff <= rst ? {NUM_IRQ{1'b0}} : pending_ff;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rsv; !irq_line[23] && !irq_line[29] && !irq_line[30]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved line raised");
    property p_spi; irq_line[20] == |(spi_flags & spi_flag_en); endproperty
    a_spi: assert property (p_spi) else $error("spi line mismatch");
    property p_t16; irq_line[16] == |t16_match; endproperty
    a_t16: assert property (p_t16) else $error("timer16 line mismatch");
    property p_brown; $rose(brownout) |-> irq_line[19] ##1 pending_ff[19]; endproperty
    a_brown: assert property (p_brown) else $error("brownout not pended");
    property p_stack; $rose(stacking_ff) |-> stacking_ff[*8] ##1 (!stacking_ff && handler_start_ff); endproperty
    a_stack: assert property (p_stack) else $error("entry save length wrong");
    property p_unstack; $rose(unstacking_ff) |-> unstacking_ff[*8] ##1 !unstacking_ff; endproperty
    a_unstack: assert property (p_unstack) else $error("exit restore length wrong");
    property p_level; $rose(stacking_ff) |-> run_level_ff < $past(run_level_ff); endproperty
    a_level: assert property (p_level) else $error("entry without higher urgency");
    property p_vec; $rose(stacking_ff) |-> pend_q_ff[vector_ff]; endproperty
    a_vec: assert property (p_vec) else $error("vector of a line not pending");
endmodule // vic_ctrl_props
bind vic_ctrl vic_ctrl_props #(.NUM_IRQ(NUM_IRQ)) i_vic_ctrl_props (.clk(clk), .rst(rst), .irq_line(irq_line),
    .pending_ff(pending_ff), .vector_ff(vector_ff), .run_level_ff(run_level_ff), .stacking_ff(stacking_ff),
    .unstacking_ff(unstacking_ff), .handler_start_ff(handler_start_ff), .spi_flags(spi_flags),
    .spi_flag_en(spi_flag_en), .t16_match(t16_match), .brownout(brownout));

// [tb/vic_core_model.sv]
// vic_core_model.sv: processor side, runs each handler for hold_cyc cycles then returns
// assumes handler_start_ff pulses once per entry
`timescale 1ns/1ps
module vic_core_model (
    input wire clk, // core clock
    input wire rst, // sync reset
    input wire handler_start_ff, // handler begins
    input wire busy, // save or restore running
    input wire [7:0] hold_cyc, // handler length
    output reg exc_return // return pulse
);
    reg [7:0] cnt_ff;
    reg [2:0] depth_ff;
    // a resumed outer handler restarts its full length: simple, and still nests correctly
    always @(posedge clk) begin
        exc_return <= !rst && !handler_start_ff && !busy && cnt_ff == 8'h1;
        if (rst) begin
            cnt_ff <= 8'h0;
            depth_ff <= 3'h0;
        end else if (handler_start_ff) begin
            depth_ff <= depth_ff + 3'h1;
            cnt_ff <= hold_cyc;
        end else if (!busy && cnt_ff == 8'h1) begin
            cnt_ff <= (depth_ff > 3'h1) ? hold_cyc : 8'h0;
            depth_ff <= depth_ff - 3'h1;
        end else if (!busy && cnt_ff != 8'h0) begin
            cnt_ff <= cnt_ff - 8'h1;
        end
    end
endmodule // vic_core_model

// [tb/vic_ctrl_tb.sv]
// vic_ctrl_tb.sv: self-checking bench for the interrupt controller
// assumes sources on src bits, one flag of each group chosen by fsel
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module vic_ctrl_tb;
    reg clk = 0, rst = 1;
    reg [31:0] src = 0, en = 0, pset = 0, pclr = 0, want = 0;
    reg [63:0] prio = {64{1'b1}};
    reg [3:0] fen = 4'hf;
    reg [1:0] fsel = 0;
    reg [7:0] hold = 8'h14;
    wire exc_return, stacking_ff, unstacking_ff, handler_start_ff;
    wire [31:0] irq_line, pending_ff, active_ff;
    wire [4:0] vector_ff;
    wire [2:0] run_level_ff;
    integer n_errors = 0, n_compared = 0, i, k;
    initial forever #10 clk = ~clk;
    vic_ctrl i_vic_ctrl (.clk(clk), .rst(rst), .wake_pin(src[10:0]), .nfc_ext_access(src[11]), .rtc_wake(src[12]),
        .nfc_flags({2'h0, src[13]} << fsel), .rtc_event(src[14]), .i2c_state_change(src[15]),
        .t16_match({2'h0, src[16]} << fsel), .pwr_field_det(src[17]), .t32_match({1'h0, src[18]} << fsel),
        .brownout(src[19]), .spi_flags({3'h0, src[20]} << fsel), .spi_flag_en(fen),
        .temp_flags({2'h0, src[21]} << fsel), .temp_flag_en(fen[2:0]), .cap_flags({2'h0, src[22]} << fsel),
        .cap_flag_en(fen[2:0]), .cur_flags({2'h0, src[24]} << fsel), .cur_flag_en(fen[2:0]),
        .adc_irq(src[25]), .wdt_irq(src[26]), .flash_irq(src[27]), .ee_irq(src[28]), .gpio_status(src[31]),
        .irq_enable(en), .sw_pend_set(pset), .sw_pend_clr(pclr), .irq_prio(prio), .exc_return(exc_return),
        .irq_line(irq_line), .pending_ff(pending_ff), .active_ff(active_ff), .vector_ff(vector_ff),
        .run_level_ff(run_level_ff), .stacking_ff(stacking_ff), .unstacking_ff(unstacking_ff),
        .handler_start_ff(handler_start_ff));
    vic_core_model i_vic_core_model (.clk(clk), .rst(rst), .handler_start_ff(handler_start_ff),
        .busy(stacking_ff | unstacking_ff), .hold_cyc(hold), .exc_return(exc_return));
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task pend(input [31:0] m);
        pset = m;
        tick(1);
        pset = 0;
    endtask
    task wait_start;
        for (k = 0; k < 100 && handler_start_ff !== 1'b1; k++) tick(1);
        `CHK(handler_start_ff, 1'b1)
        tick(1);
    endtask
    task wait_idle;
        for (k = 0; k < 1500 && (run_level_ff !== 3'h4 || unstacking_ff !== 1'b0); k++) tick(1);
    endtask
    task t_map;
        // wake pins pass a synchroniser, so allow a few cycles per step
        // third pass shifts the two-flag timer group out, so its line must stay low
        for (i = 0; i < 96; i++) begin
            fsel = i / 32;
            src = 32'h1 << (i % 32);
            want = src & (fsel[1] ? 32'h9f7bffff : 32'h9f7fffff);
            tick(5);
            `CHK(irq_line, want)
        end
        fen = 0;
        src = 32'h01700000;
        tick(1);
        `CHK(irq_line, 32'h0)
        {fen, fsel} = {4'h8, 2'h3};
        tick(1);
        `CHK(irq_line, 32'h00100000)
        {fen, src, fsel, pclr} = {4'hf, 32'h0, 2'h0, 32'hffffffff};
        tick(1);
        pclr = 0;
    endtask
    task t_order;
        en = 32'hffffffff;
        prio[33:32] = 2'h1;
        prio[39:38] = 2'h1;
        pend(32'h00090000);
        wait_start;
        `CHK(vector_ff, 5'h10)
        wait_start;
        `CHK(vector_ff, 5'h13)
        wait_idle;
        `CHK({run_level_ff, active_ff}, {3'h4, 32'h0})
    endtask
    task t_preempt;
        hold = 8'hc8;
        prio[29:28] = 2'h0;
        pend(32'h00010000);
        wait_start;
        pend(32'h00008000);
        tick(12);
        `CHK({stacking_ff, vector_ff}, {1'b0, 5'h10})
        pclr = 32'h00008000;
        tick(1);
        pclr = 0;
        pend(32'h00004000);
        wait_start;
        `CHK({vector_ff, active_ff}, {5'h0e, 32'h00014000})
        wait_idle;
        `CHK(run_level_ff, 3'h4)
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        tick(2);
        rst = 0;
        `CHK({run_level_ff, pending_ff, active_ff}, {3'h4, 64'h0})
        `CHK({vector_ff, stacking_ff, unstacking_ff, handler_start_ff}, 8'h00)
        t_map;
        t_order;
        t_preempt;
        tally_and_finish;
    end
endmodule // vic_ctrl_tb
